// File: include/trc_params.svh
// Constants for the transceiver reset and reconfiguration controller
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH

// ==========================================================
// Register bus
`define TRC_ADDR_W        4
`define TRC_DATA_W        8
`define TRC_OFS_CTRL      4'h0
`define TRC_OFS_STATUS    4'h1
`define TRC_OFS_COMMIT    4'h2
`define TRC_OFS_CFG_BASE  4'h8
`define TRC_OFS_CFG_LAST  4'he

// ==========================================================
// Control register fields
`define TRC_CTRL_RXD      0
`define TRC_CTRL_RXA      1
`define TRC_CTRL_TXD      2
`define TRC_CTRL_PD       3
`define TRC_CTRL_EN       4
`define TRC_CTRL_RESET    8'h10
`define TRC_COMMIT_GO     0

// ==========================================================
// Status register fields
`define TRC_STAT_RXD      0
`define TRC_STAT_RXA      1
`define TRC_STAT_TXD      2
`define TRC_STAT_GLOB     3
`define TRC_STAT_BUSY     4

// ==========================================================
// Settings store
`define TRC_CFG_IDX_W     3
`define TRC_CFG_WORDS     8
`define TRC_CFG_USED      7
`define TRC_CFG_LAST_IDX  3'h6
`define TRC_CFG_RESET     8'h00

// ==========================================================
// Engine step rate
`define TRC_SYS_CLK_HZ    100_000_000
`define TRC_RCFG_CLK_HZ   25_000_000
`define TRC_RCFG_DIV      (`TRC_SYS_CLK_HZ / `TRC_RCFG_CLK_HZ)
`define TRC_DIV_W         4
`define TRC_DIV_LAST      4'((`TRC_RCFG_DIV) - 1)

`endif

// File: include/trc_pkg.sv
// Types shared by the transceiver reset and reconfiguration controller
`include "trc_params.svh"

package trc_pkg;

    // ======================================================
    // Register bus request
    typedef struct packed {
        logic [`TRC_ADDR_W-1:0] addr;
        logic [`TRC_DATA_W-1:0] wdata;
        logic                   we;
        logic                   re;
    } trc_bus_req_t;

    // ======================================================
    // Reset request lines from fabric or pins
    typedef struct packed {
        logic rx_digital;
        logic rx_analog;
        logic tx_digital;
        logic powerdown;
        logic enable;
    } trc_rst_in_t;

    // ======================================================
    // Per sub-block reset, high holds the sub-block
    typedef struct packed {
        logic tx_phase_comp;
        logic tx_encoder;
        logic tx_serializer;
        logic tx_analog;
        logic tx_pll;
        logic tx_xaui_fsm;
        logic selftest_gen;
        logic rx_deserializer;
        logic rx_word_align;
        logic rx_deskew;
        logic rx_rate_match;
        logic rx_decoder;
        logic rx_phase_comp;
        logic rx_pll_recovery;
        logic rx_xaui_fsm;
        logic selftest_chk;
        logic rx_analog;
    } trc_sub_rst_t;

    // ======================================================
    // Applied settings
    typedef struct packed {
        logic [`TRC_DATA_W-1:0] preemphasis;
        logic [`TRC_DATA_W-1:0] equalizer;
        logic [`TRC_DATA_W-1:0] dc_gain;
        logic [`TRC_DATA_W-1:0] diff_output_swing;
    } trc_pma_cfg_t;

    typedef struct packed {
        logic [`TRC_DATA_W-1:0] data_rate;
        logic [`TRC_DATA_W-1:0] local_divider;
        logic [`TRC_DATA_W-1:0] func_mode;
    } trc_chan_cfg_t;

    typedef enum logic [1:0] {
        TRC_IDLE,
        TRC_FETCH,
        TRC_APPLY
    } trc_eng_state_t;

endpackage : trc_pkg

// File: core/trc_cfg_mem.sv
// Staging memory for pending reconfiguration settings
`include "trc_params.svh"

module trc_cfg_mem (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Write port
    input  wire logic                      wr_en,
    input  wire logic [`TRC_CFG_IDX_W-1:0] wr_idx,
    input  wire logic [`TRC_DATA_W-1:0]    wr_data,
    // Registered read port
    input  wire logic [`TRC_CFG_IDX_W-1:0] rd_idx,
    output logic      [`TRC_DATA_W-1:0]    rd_data
);

    logic [`TRC_DATA_W-1:0] mem [`TRC_CFG_WORDS];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `TRC_CFG_WORDS; i++) begin
                mem[i] <= `TRC_CFG_RESET;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `TRC_CFG_RESET;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end

endmodule : trc_cfg_mem

// File: core/trc_reset_ctrl.sv
// Transceiver reset, power-down and reconfiguration controller top
//
// Added by the designer: the plain strobed port and the register offsets.
`include "trc_params.svh"

module trc_reset_ctrl (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // Reset controls from pins or fabric
    input  trc_pkg::trc_rst_in_t        rst_in,
    // Register port
    input  trc_pkg::trc_bus_req_t       bus_req,
    output logic [`TRC_DATA_W-1:0]      rdata,
    // Sub-block resets
    output trc_pkg::trc_sub_rst_t       sub_rst,
    // Applied settings
    output trc_pkg::trc_pma_cfg_t       pma_cfg,
    output trc_pkg::trc_chan_cfg_t      chan_cfg,
    output logic                        rcfg_busy
);
    import trc_pkg::*;

    // ======================================================
    // Effective controls
    logic [`TRC_DATA_W-1:0]    ctrl;
    logic                      rxd_req;
    logic                      rxa_req;
    logic                      txd_req;
    logic                      glob_req;

    // Either source may assert a reset; both must enable
    assign rxd_req  = rst_in.rx_digital | ctrl[`TRC_CTRL_RXD];
    assign rxa_req  = rst_in.rx_analog  | ctrl[`TRC_CTRL_RXA];
    assign txd_req  = rst_in.tx_digital | ctrl[`TRC_CTRL_TXD];
    assign glob_req = rst_in.powerdown | ctrl[`TRC_CTRL_PD]
                    | ~(rst_in.enable & ctrl[`TRC_CTRL_EN]);

    function automatic trc_sub_rst_t map_rst(input logic rxd,
                                             input logic rxa,
                                             input logic txd,
                                             input logic glob);
        trc_sub_rst_t r;
        r.tx_phase_comp   = txd | glob;
        r.tx_encoder      = txd | glob;
        r.tx_serializer   = glob;
        r.tx_analog       = glob;
        r.tx_pll          = glob;
        r.tx_xaui_fsm     = txd | glob;
        r.selftest_gen    = txd | glob;
        r.rx_deserializer = rxa | glob;
        r.rx_word_align   = rxd | glob;
        r.rx_deskew       = rxd | glob;
        r.rx_rate_match   = rxd | glob;
        r.rx_decoder      = rxd | glob;
        r.rx_phase_comp   = rxd | glob;
        r.rx_pll_recovery = rxa | glob;
        r.rx_xaui_fsm     = rxd | glob;
        r.selftest_chk    = rxd | glob;
        r.rx_analog       = rxa | glob;
        return r;
    endfunction : map_rst

    // Whole block held under system reset; released one edge later
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sub_rst <= '1;
        end else begin
            sub_rst <= map_rst(rxd_req, rxa_req, txd_req, glob_req);
        end
    end

    // ======================================================
    // Register decode
    logic                      cfg_hit;
    logic [`TRC_CFG_IDX_W-1:0] cfg_idx;
    logic                      commit_go;
    trc_eng_state_t            state;

    assign cfg_hit   = (bus_req.addr >= `TRC_OFS_CFG_BASE)
                     && (bus_req.addr <= `TRC_OFS_CFG_LAST);
    assign cfg_idx   = bus_req.addr[`TRC_CFG_IDX_W-1:0];
    assign commit_go = bus_req.we && (bus_req.addr == `TRC_OFS_COMMIT)
                     && bus_req.wdata[`TRC_COMMIT_GO];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `TRC_CTRL_RESET;
        end else if (bus_req.we && bus_req.addr == `TRC_OFS_CTRL) begin
            ctrl <= bus_req.wdata;
        end
    end

    // ======================================================
    // Engine step divider
    logic [`TRC_DIV_W-1:0]     div_cnt;
    logic                      step;

    // Step rate fixed inside the legal engine range
    assign step = (div_cnt == `TRC_DIV_LAST);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= '0;
        end else if (step) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ======================================================
    // Reconfiguration engine
    logic [`TRC_CFG_IDX_W-1:0] eng_idx;
    logic [`TRC_DATA_W-1:0]    mem_rd;
    logic [`TRC_DATA_W-1:0]    active [`TRC_CFG_USED];

    trc_cfg_mem u_mem (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (bus_req.we && cfg_hit),
        .wr_idx  (cfg_idx),
        .wr_data (bus_req.wdata),
        .rd_idx  (eng_idx),
        .rd_data (mem_rd)
    );

    // Commit while busy is dropped, so a walk is never torn
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= TRC_IDLE;
            eng_idx <= '0;
        end else begin
            unique case (state)
                TRC_IDLE: begin
                    if (commit_go) begin
                        state   <= TRC_FETCH;
                        eng_idx <= '0;
                    end
                end
                TRC_FETCH: begin
                    if (step) begin
                        state <= TRC_APPLY;
                    end
                end
                TRC_APPLY: begin
                    if (eng_idx == `TRC_CFG_LAST_IDX) begin
                        state <= TRC_IDLE;
                    end else begin
                        state   <= TRC_FETCH;
                        eng_idx <= eng_idx + 1'b1;
                    end
                end
            endcase
        end
    end

    // Settings change live; the channel keeps running meanwhile
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `TRC_CFG_USED; i++) begin
                active[i] <= `TRC_CFG_RESET;
            end
        end else if (state == TRC_APPLY) begin
            active[eng_idx] <= mem_rd;
        end
    end

    assign rcfg_busy = (state != TRC_IDLE);
    assign pma_cfg   = {active[0], active[1], active[2], active[3]};
    assign chan_cfg  = {active[4], active[5], active[6]};

    // ======================================================
    // Read data, valid in the cycle after the strobe only
    logic [`TRC_DATA_W-1:0]    status;

    always_comb begin
        status = '0;
        status[`TRC_STAT_RXD]  = rxd_req;
        status[`TRC_STAT_RXA]  = rxa_req;
        status[`TRC_STAT_TXD]  = txd_req;
        status[`TRC_STAT_GLOB] = glob_req;
        status[`TRC_STAT_BUSY] = rcfg_busy;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (!bus_req.re) begin
            rdata <= '0;
        end else if (bus_req.addr == `TRC_OFS_CTRL) begin
            rdata <= ctrl;
        end else if (bus_req.addr == `TRC_OFS_STATUS) begin
            rdata <= status;
        end else if (cfg_hit && cfg_idx <= `TRC_CFG_LAST_IDX) begin
            rdata <= active[cfg_idx];
        end else begin
            rdata <= '0;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_commit;
        commit_go && !rcfg_busy;
    endsequence

    sequence s_walk_done;
        ##[20:60] !rcfg_busy;
    endsequence

    a_rx_dig_map: assert property (
        rxd_req |=> sub_rst.rx_word_align && sub_rst.rx_deskew
            && sub_rst.rx_rate_match && sub_rst.rx_decoder
            && sub_rst.rx_phase_comp && sub_rst.rx_xaui_fsm
            && sub_rst.selftest_chk)
        else $error("rx digital reset missed a sub-block");

    a_rx_dig_iso: assert property (
        rxd_req && !rxa_req && !glob_req |=> !sub_rst.rx_deserializer
            && !sub_rst.rx_pll_recovery && !sub_rst.rx_analog)
        else $error("rx digital reset hit rx analog parts");

    a_rx_ana_map: assert property (
        rxa_req && !txd_req && !glob_req |=> sub_rst.rx_deserializer
            && sub_rst.rx_pll_recovery && sub_rst.rx_analog
            && !sub_rst.tx_phase_comp && !sub_rst.tx_pll)
        else $error("rx analog reset mapping wrong");

    a_tx_dig_map: assert property (
        txd_req && !glob_req |=> sub_rst.tx_phase_comp
            && sub_rst.tx_encoder && sub_rst.tx_xaui_fsm
            && sub_rst.selftest_gen && !sub_rst.tx_serializer
            && !sub_rst.tx_analog && !sub_rst.tx_pll)
        else $error("tx digital reset mapping wrong");

    a_global_all: assert property (
        glob_req |=> (&sub_rst))
        else $error("global control missed a sub-block");

    a_hold_release: assert property (
        !rxd_req && !rxa_req && !txd_req && !glob_req |=> sub_rst == '0)
        else $error("sub-block held after release");

    a_commit_walk: assert property (
        s_commit |=> rcfg_busy ##0 s_walk_done)
        else $error("reconfiguration walk out of bounds");

    a_step_period: assert property (
        step |=> !step [*3] ##1 step)
        else $error("engine step period wrong");

    a_read_once: assert property (
        !bus_req.re |=> rdata == '0)
        else $error("read data outside its cycle");

endmodule : trc_reset_ctrl

// File: sim/trc_fabric_model.sv
// Fabric side model that drives the reset request lines
`include "trc_params.svh"

module trc_fabric_model (
    // Clock
    input  wire logic            clock,
    // Requests from the pin source and the fabric source
    input  trc_pkg::trc_rst_in_t pin_req,
    input  trc_pkg::trc_rst_in_t fab_req,
    input  wire logic            use_pin,
    // Lines into the controller
    output trc_pkg::trc_rst_in_t rst_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import trc_pkg::*;

    // ==========================================================
    // Source select
    // Both sources share one flop, so the controller sees no difference
    always_ff @(posedge clock) begin
        rst_in <= use_pin ? pin_req : fab_req;
    end

endmodule : trc_fabric_model

// File: sim/trc_reset_ctrl_bench.sv
// Self-checking bench for the reset and reconfiguration controller
`include "trc_params.svh"

module trc_reset_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import trc_pkg::*;

    logic          clock;
    logic          sys_rst;
    logic          use_pin;
    trc_rst_in_t   pin_req;
    trc_rst_in_t   fab_req;
    trc_rst_in_t   rst_in;
    trc_bus_req_t  bus_req;
    logic [7:0]    rdata;
    trc_sub_rst_t  sub_rst;
    trc_pma_cfg_t  pma_cfg;
    trc_chan_cfg_t chan_cfg;
    logic          rcfg_busy;
    int            miscompares;
    int            num_checks;
    int            n;
    logic [7:0]    d;
    logic [7:0]    vals [7];
    // Patterns {rxd,rxa,txd,pd,en}; the last pairs rx analog with tx digital
    logic [4:0]    pat [6] = '{5'h11, 5'h09, 5'h05, 5'h03, 5'h00, 5'h0d};

    trc_fabric_model u_fabric (.clock(clock), .pin_req(pin_req),
        .fab_req(fab_req), .use_pin(use_pin), .rst_in(rst_in));

    trc_reset_ctrl u_dut (.clock(clock), .sys_rst(sys_rst),
        .rst_in(rst_in), .bus_req(bus_req), .rdata(rdata),
        .sub_rst(sub_rst), .pma_cfg(pma_cfg), .chan_cfg(chan_cfg),
        .rcfg_busy(rcfg_busy));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // Expectations
    function automatic trc_sub_rst_t exp_mask(input logic [4:0] p);
        logic g;
        g = p[1] | ~p[0];
        return '{tx_phase_comp: p[2] | g, tx_encoder: p[2] | g,
            tx_serializer: g, tx_analog: g, tx_pll: g,
            tx_xaui_fsm: p[2] | g, selftest_gen: p[2] | g,
            rx_deserializer: p[3] | g, rx_word_align: p[4] | g,
            rx_deskew: p[4] | g, rx_rate_match: p[4] | g,
            rx_decoder: p[4] | g, rx_phase_comp: p[4] | g,
            rx_pll_recovery: p[3] | g, rx_xaui_fsm: p[4] | g,
            selftest_chk: p[4] | g, rx_analog: p[3] | g};
    endfunction : exp_mask

    function automatic logic [7:0] exp_stat(input logic [4:0] p);
        return {4'h0, p[1] | ~p[0], p[2], p[3], p[4]};
    endfunction : exp_stat

    // ==========================================================
    // Compare tasks
    task automatic chk_val(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_sub(input trc_sub_rst_t got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_sub

    task automatic chk_bit(input logic got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %b", $time, what, got);
        end
    endtask : chk_bit

    // ==========================================================
    // Bus and timing tasks
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        bus_req.addr  <= a;
        bus_req.wdata <= v;
        bus_req.we    <= 1'b1;
        @(posedge clock);
        bus_req.we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        bus_req.addr <= a;
        bus_req.re   <= 1'b1;
        @(posedge clock);
        bus_req.re   <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // Model flop plus the controller's own register stage
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic summarize();
        $display("Checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Watchdog, far above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    // ==========================================================
    // Tests
    initial begin
        sys_rst = 1'b1;
        use_pin = 1'b0;
        pin_req = 5'h01;
        fab_req = 5'h01;
        bus_req = '0;
        repeat (2) @(posedge clock);
        #1;
        chk_sub(sub_rst, '1, "hold in reset");
        @(posedge clock);
        sys_rst <= 1'b0;
        settle();
        chk_sub(sub_rst, '0, "released");
        rd(4'h0, d);
        chk_val(32'(d), 32'h10, "ctrl reset");
        rd(4'h1, d);
        chk_val(32'(d), 32'h0, "status idle");
        $display("Test reset done");

        // Unused source shows the inverse so a wrong pick shows up
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            use_pin <= i[0];
            pin_req <= i[0] ? pat[i] : ~pat[i];
            fab_req <= i[0] ? ~pat[i] : pat[i];
            settle();
            repeat (4) begin
                chk_sub(sub_rst, exp_mask(pat[i]), "pin map");
                @(posedge clock);
                #1;
            end
            rd(4'h1, d);
            chk_val(32'(d), 32'(exp_stat(pat[i])), "status");
            @(posedge clock);
            pin_req <= 5'h01;
            fab_req <= 5'h01;
            settle();
            chk_sub(sub_rst, '0, "pin release");
        end
        $display("Test pin mapping done");

        for (int i = 0; i < 6; i++) begin
            wr(4'h0, {3'h0, pat[i][0], pat[i][1], pat[i][2], pat[i][3],
                pat[i][4]});
            settle();
            chk_sub(sub_rst, exp_mask(pat[i]), "ctrl map");
        end
        wr(4'h0, 8'hf0);
        rd(4'h0, d);
        chk_val(32'(d), 32'hf0, "ctrl readback");
        settle();
        chk_sub(sub_rst, '0, "ctrl release");
        $display("Test ctrl mapping done");

        for (int i = 0; i < 7; i++) begin
            vals[i] = 8'h31 + 8'(i * 17);
            wr(4'h8 + 4'(i), vals[i]);
        end
        // Commit with the start bit clear must not start a walk
        wr(4'h2, 8'hfe);
        #1;
        chk_bit(rcfg_busy, 1'b0, "commit bit clear");
        wr(4'h2, 8'h01);
        #1;
        chk_bit(rcfg_busy, 1'b1, "busy after commit");
        wr(4'h2, 8'h01);
        n = 0;
        while (rcfg_busy === 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        // One entry per divider period; count starts two edges late
        d = 8'(`TRC_CFG_USED * `TRC_RCFG_DIV);
        chk_bit(n + `TRC_RCFG_DIV >= d && n < d, 1'b1, "walk");
        chk_val(pma_cfg, {vals[0], vals[1], vals[2], vals[3]}, "pma");
        chk_val(32'(chan_cfg), {8'h0, vals[4], vals[5], vals[6]}, "chan");
        repeat (5) @(posedge clock);
        #1;
        chk_bit(rcfg_busy, 1'b0, "busy commit ignored");
        for (int i = 0; i < 7; i++) begin
            rd(4'h8 + 4'(i), d);
            chk_val(32'(d), 32'(vals[i]), "applied readback");
        end
        chk_sub(sub_rst, '0, "channel kept running");
        $display("Test reconfiguration done");

        wr(4'h1, 8'hff);
        rd(4'h1, d);
        chk_val(32'(d), 32'h0, "status read only");
        rd(4'h5, d);
        chk_val(32'(d), 32'h0, "unmapped read");
        rd(4'hf, d);
        chk_val(32'(d), 32'h0, "unmapped top");
        @(posedge clock);
        #1;
        chk_val(32'(rdata), 32'h0, "rdata one cycle");
        $display("Test register map done");
        summarize();
    end

endmodule : trc_reset_ctrl_bench
